/* File: bss_pkg.sv */
// Package with constants and types for the boost startup and fault sequencer.
package bss_pkg;
	// Clock period in picoseconds (250 MHz).
	localparam int CLK_PERIOD_PS = 4000;
	// Soft-start timeout, in microseconds.
	localparam int SS_TIMEOUT_US = 3000;
	// Scaled in two steps so that the product stays inside a 32-bit int.
	localparam int SS_TIMEOUT_CYCLES = SS_TIMEOUT_US * 1000 / (CLK_PERIOD_PS / 1000);
	// Soft-start step count and default step interval (timeout split over the steps).
	localparam int SS_STEPS = 128;
	localparam int SS_STEP_CYCLES = SS_TIMEOUT_CYCLES / SS_STEPS;
	// Fault timer duration in microseconds.
	localparam int FAULT_TIME_US = 50000;
	localparam int FAULT_CYCLES = FAULT_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
	localparam int CNT_W = 24;
	localparam int STEP_W = 8;

	// Register offsets (byte addresses).
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_STEP = 8'h10;

	// Interrupt event bit positions.
	localparam int EV_FAULT = 0;
	localparam int EV_THERMAL = 1;
	localparam int EV_SS_DONE = 2;
	localparam int EV_LOCKOUT = 3;
	localparam int EV_RAIL_BLOCK = 4;
	localparam int EV_W = 5;

	// Control register: bit 0 is a software regulator disable.
	localparam int CTRL_SW_OFF = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_OPEN_LOOP = 6'h02,
		ST_REF_WAIT = 6'h04,
		ST_SOFT_START = 6'h08,
		ST_RUN = 6'h10,
		ST_FAULT = 6'h20
	} bss_state_type;
endpackage

/* File: bss_flag_if.sv */
// Interface carrying synchronised comparator flags to the sequencer core.
`timescale 1ns/1ps
interface bss_flag_if;
	logic in_above_rise;
	logic in_below_fall;
	logic rail_uv;
	logic rail_ov;
	logic internal_supply_rail_ok;
	logic ref_ready;
	logic feedback_sense_low;
	logic feedback_sense_reg;
	logic over_temp;
	logic regulator_disable_n;
	modport src (output in_above_rise, in_below_fall, rail_uv, rail_ov,
		internal_supply_rail_ok, ref_ready, feedback_sense_low, feedback_sense_reg,
		over_temp, regulator_disable_n);
	modport dst (input in_above_rise, in_below_fall, rail_uv, rail_ov,
		internal_supply_rail_ok, ref_ready, feedback_sense_low, feedback_sense_reg,
		over_temp, regulator_disable_n);
endinterface

/* File: bss_sync.sv */
// Two-flop synchroniser bank for the comparator flags.
`timescale 1ns/1ps
module bss_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [9:0] raw,
	bss_flag_if.src flags
);
	logic [9:0] meta_q;
	logic [9:0] sync_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 10'h000;
			sync_q <= 10'h000;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	assign flags.in_above_rise = sync_q[0];
	assign flags.in_below_fall = sync_q[1];
	assign flags.rail_uv = sync_q[2];
	assign flags.rail_ov = sync_q[3];
	assign flags.internal_supply_rail_ok = sync_q[4];
	assign flags.ref_ready = sync_q[5];
	assign flags.feedback_sense_low = sync_q[6];
	assign flags.feedback_sense_reg = sync_q[7];
	assign flags.over_temp = sync_q[8];
	assign flags.regulator_disable_n = sync_q[9];
endmodule

/* File: bss_sequencer.sv */
// Boost regulator startup and fault sequencer with a Wishbone register slave.
// Operation
// - Input supply valid above upper threshold, stays valid until below lower threshold.
// - Input lockout turns off boost, linear regulator, switch control; amplifier hi-Z.
// - Overall enable needs input valid, rail above lockout and fault latch clear.
// - After enable, run the power switch open-loop to build the internal supply.
// - Turn on internal reference only after internal supply rail flag is high.
// - On reference ready, enable PWM and current limit, enter soft-start.
// - Soft-start raises current limit in equal steps, step index counts to full.
// - Soft-start ends on regulation or timer expiry, whichever comes first.
// - In steady state, feedback-low starts the fault timer.
// - Feedback-low held for full timer sets fault latch and shuts outputs off.
// - Fault latch holds until the input supply is cycled through lockout.
// - Feedback fault detection and timer are held off during soft-start.
// - Rail undervoltage or overvoltage disables the gate driver while present.
// - Rail undervoltage and overvoltage never set the fault latch.
// - Over-temperature sets a thermal latch shutting everything off until supply cycles.
// - Regulator-disable low stops only the boost; amplifier and switch control stay.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module bss_sequencer #(
	parameter int SS_STEP_CYCLES = bss_pkg::SS_STEP_CYCLES,
	parameter int SS_TIMEOUT_CYCLES = bss_pkg::SS_TIMEOUT_CYCLES,
	parameter int FAULT_CYCLES = bss_pkg::FAULT_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_above_rise,
	input wire logic in_below_fall,
	input wire logic rail_uv,
	input wire logic rail_ov,
	input wire logic internal_supply_rail_ok,
	input wire logic ref_ready,
	input wire logic feedback_sense_low,
	input wire logic feedback_sense_reg,
	input wire logic over_temp,
	input wire logic regulator_disable_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic device_enable,
	output logic open_loop_en,
	output logic pwm_en,
	output logic current_limit_en,
	output logic gate_drive_en,
	output logic linear_reg_en,
	output logic switch_ctrl_en,
	output logic amp_out_en,
	output logic reference_en,
	output logic [7:0] ss_step,
	output logic irq
);
	bss_flag_if flags ();

	bss_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.raw({regulator_disable_n, over_temp, feedback_sense_reg, feedback_sense_low,
			ref_ready, internal_supply_rail_ok, rail_ov, rail_uv, in_below_fall,
			in_above_rise}),
		.flags(flags)
	);

	bss_pkg::bss_state_type state_q;
	logic in_valid_q;
	logic fault_q;
	logic thermal_q;
	logic [bss_pkg::CNT_W-1:0] step_cnt_q;
	logic [bss_pkg::CNT_W-1:0] ss_time_q;
	logic [bss_pkg::CNT_W-1:0] fault_cnt_q;
	logic [bss_pkg::STEP_W-1:0] step_q;
	logic [bss_pkg::EV_W-1:0] irq_stat_q;
	logic [bss_pkg::EV_W-1:0] irq_mask_q;
	logic [31:0] ctrl_q;
	logic rail_block_q;
	logic ack_q;

	logic lockout;
	logic latched;
	logic rail_bad;
	logic enable;
	logic ss_done;
	logic fault_hit;
	logic sw_off;
	logic boost_allowed;
	logic [bss_pkg::EV_W-1:0] events;
	logic wb_req;
	logic wb_wr;
	logic addr_ok;

	// Lockout is the inverse of the hysteretic input-valid state.
	assign lockout = !in_valid_q;
	assign latched = fault_q || thermal_q;
	// Rail lockout uses the undervoltage flag only; overvoltage just blocks switching.
	assign enable = in_valid_q && !flags.rail_uv && !latched;
	assign rail_bad = flags.rail_uv || flags.rail_ov;
	assign ss_done = flags.feedback_sense_reg ||
		(ss_time_q >= bss_pkg::CNT_W'(SS_TIMEOUT_CYCLES - 1));
	assign fault_hit = (state_q == bss_pkg::ST_RUN) && flags.feedback_sense_low &&
		(fault_cnt_q >= bss_pkg::CNT_W'(FAULT_CYCLES - 1));
	assign sw_off = ctrl_q[bss_pkg::CTRL_SW_OFF];
	assign boost_allowed = flags.regulator_disable_n && !sw_off;

	// Upper threshold sets valid, lower threshold clears it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_valid_q <= 1'b0;
		end else if (flags.in_below_fall) begin
			in_valid_q <= 1'b0;
		end else if (flags.in_above_rise) begin
			in_valid_q <= 1'b1;
		end
	end

	// Sequencer state machine.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= bss_pkg::ST_IDLE;
		end else if (lockout) begin
			state_q <= bss_pkg::ST_IDLE;
		end else if (latched || fault_hit || flags.over_temp) begin
			state_q <= bss_pkg::ST_FAULT;
		end else begin
			case (state_q)
				bss_pkg::ST_IDLE: begin
					if (enable && boost_allowed) begin
						state_q <= bss_pkg::ST_OPEN_LOOP;
					end
				end
				bss_pkg::ST_OPEN_LOOP: begin
					if (!boost_allowed) begin
						state_q <= bss_pkg::ST_IDLE;
					end else if (flags.internal_supply_rail_ok) begin
						state_q <= bss_pkg::ST_REF_WAIT;
					end
				end
				bss_pkg::ST_REF_WAIT: begin
					if (!boost_allowed) begin
						state_q <= bss_pkg::ST_IDLE;
					end else if (flags.ref_ready) begin
						state_q <= bss_pkg::ST_SOFT_START;
					end
				end
				bss_pkg::ST_SOFT_START: begin
					if (!boost_allowed) begin
						state_q <= bss_pkg::ST_IDLE;
					end else if (ss_done) begin
						state_q <= bss_pkg::ST_RUN;
					end
				end
				bss_pkg::ST_RUN: begin
					if (!boost_allowed) begin
						state_q <= bss_pkg::ST_IDLE;
					end
				end
				bss_pkg::ST_FAULT: begin
					state_q <= bss_pkg::ST_FAULT;
				end
				default: begin
					state_q <= bss_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Soft-start timer and step ramp.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ss_time_q <= '0;
			step_cnt_q <= '0;
			step_q <= 8'h00;
		end else if (state_q != bss_pkg::ST_SOFT_START && state_q != bss_pkg::ST_RUN) begin
			ss_time_q <= '0;
			step_cnt_q <= '0;
			step_q <= 8'h00;
		end else if (state_q == bss_pkg::ST_RUN) begin
			// Once regulated, the full limit applies regardless of the ramp.
			step_q <= 8'(bss_pkg::SS_STEPS);
		end else begin
			ss_time_q <= ss_time_q + 1'b1;
			if (step_cnt_q >= bss_pkg::CNT_W'(SS_STEP_CYCLES - 1)) begin
				step_cnt_q <= '0;
				if (step_q < 8'(bss_pkg::SS_STEPS)) begin
					step_q <= step_q + 8'h01;
				end
			end else begin
				step_cnt_q <= step_cnt_q + 1'b1;
			end
		end
	end

	// Fault timer restarts whenever feedback recovers, so only a continuous fault counts.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_cnt_q <= '0;
		end else if (state_q != bss_pkg::ST_RUN || !flags.feedback_sense_low) begin
			fault_cnt_q <= '0;
		end else if (!fault_hit) begin
			fault_cnt_q <= fault_cnt_q + 1'b1;
		end
	end

	// Fault latches; rail limits never feed them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_q <= 1'b0;
			thermal_q <= 1'b0;
		end else if (lockout) begin
			fault_q <= 1'b0;
			thermal_q <= 1'b0;
		end else begin
			if (fault_hit) begin
				fault_q <= 1'b1;
			end
			if (flags.over_temp) begin
				thermal_q <= 1'b1;
			end
		end
	end

	// Output enables, registered from the sequencer state and the lockout, latch, over-temperature and rail conditions.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			device_enable <= 1'b0;
			open_loop_en <= 1'b0;
			pwm_en <= 1'b0;
			current_limit_en <= 1'b0;
			gate_drive_en <= 1'b0;
			linear_reg_en <= 1'b0;
			switch_ctrl_en <= 1'b0;
			amp_out_en <= 1'b0;
			reference_en <= 1'b0;
			ss_step <= 8'h00;
		end else begin
			device_enable <= enable;
			open_loop_en <= (state_q == bss_pkg::ST_OPEN_LOOP);
			reference_en <= (state_q == bss_pkg::ST_REF_WAIT) ||
				(state_q == bss_pkg::ST_SOFT_START) || (state_q == bss_pkg::ST_RUN);
			pwm_en <= (state_q == bss_pkg::ST_SOFT_START) || (state_q == bss_pkg::ST_RUN);
			current_limit_en <= (state_q == bss_pkg::ST_SOFT_START) ||
				(state_q == bss_pkg::ST_RUN);
			gate_drive_en <= !rail_bad && !lockout && !latched && !fault_hit &&
				!flags.over_temp && boost_allowed &&
				(state_q != bss_pkg::ST_IDLE) && (state_q != bss_pkg::ST_FAULT);
			// Switch control, linear regulator and amplifier ignore the regulator disable.
			linear_reg_en <= !lockout && !latched && !flags.over_temp && !fault_hit;
			switch_ctrl_en <= !lockout && !latched && !flags.over_temp && !fault_hit;
			amp_out_en <= !lockout && !latched && !flags.over_temp && !fault_hit;
			ss_step <= step_q;
		end
	end

	// Interrupt events: latches set, soft-start done, lockout entry, rail block.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rail_block_q <= 1'b0;
		end else begin
			rail_block_q <= rail_bad;
		end
	end

	always_comb begin
		events = '0;
		events[bss_pkg::EV_FAULT] = fault_hit && !fault_q;
		events[bss_pkg::EV_THERMAL] = flags.over_temp && !thermal_q && !lockout;
		events[bss_pkg::EV_SS_DONE] = (state_q == bss_pkg::ST_SOFT_START) && ss_done &&
			boost_allowed && !latched && !lockout && !flags.over_temp;
		events[bss_pkg::EV_LOCKOUT] = flags.in_below_fall && in_valid_q;
		events[bss_pkg::EV_RAIL_BLOCK] = rail_bad && !rail_block_q;
	end

	// Wishbone classic slave, one wait state: ack follows the request by one cycle.
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o;
	assign wb_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
	assign addr_ok = (wb_adr_i == bss_pkg::ADDR_STATUS) || (wb_adr_i == bss_pkg::ADDR_IRQ_STAT) ||
		(wb_adr_i == bss_pkg::ADDR_IRQ_MASK) || (wb_adr_i == bss_pkg::ADDR_CTRL) ||
		(wb_adr_i == bss_pkg::ADDR_STEP);

	// A new event wins over a write-one-to-clear in the same cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= '0;
		end else if (wb_wr && wb_adr_i == bss_pkg::ADDR_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~wb_dat_i[bss_pkg::EV_W-1:0]) | events;
		end else begin
			irq_stat_q <= irq_stat_q | events;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask_q <= bss_pkg::MASK_RESET;
			ctrl_q <= bss_pkg::CTRL_RESET;
		end else if (wb_wr && wb_adr_i == bss_pkg::ADDR_IRQ_MASK) begin
			irq_mask_q <= wb_dat_i[bss_pkg::EV_W-1:0];
		end else if (wb_wr && wb_adr_i == bss_pkg::ADDR_CTRL) begin
			ctrl_q <= {31'h0000_0000, wb_dat_i[bss_pkg::CTRL_SW_OFF]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req && addr_ok;
			wb_err_o <= wb_req && !addr_ok;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					bss_pkg::ADDR_STATUS: begin
						wb_dat_o <= {21'h000000, in_valid_q, flags.rail_uv, flags.rail_ov,
							fault_q, thermal_q, 6'(state_q)};
					end
					bss_pkg::ADDR_IRQ_STAT: begin
						wb_dat_o <= {27'h0000000, irq_stat_q};
					end
					bss_pkg::ADDR_IRQ_MASK: begin
						wb_dat_o <= {27'h0000000, irq_mask_q};
					end
					bss_pkg::ADDR_CTRL: begin
						wb_dat_o <= ctrl_q;
					end
					bss_pkg::ADDR_STEP: begin
						wb_dat_o <= {24'h000000, step_q};
					end
					default: begin
						wb_dat_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign irq = |(irq_stat_q & irq_mask_q);
endmodule

/* File: bss_checker.sv */
// Port-level assertions for the boost startup and fault sequencer.
`timescale 1ns/1ps
module bss_checker #(
	parameter int FAULT_CYCLES = 50
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_above_rise,
	input wire logic in_below_fall,
	input wire logic rail_uv,
	input wire logic rail_ov,
	input wire logic internal_supply_rail_ok,
	input wire logic ref_ready,
	input wire logic feedback_sense_low,
	input wire logic over_temp,
	input wire logic regulator_disable_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic device_enable,
	input wire logic open_loop_en,
	input wire logic pwm_en,
	input wire logic current_limit_en,
	input wire logic gate_drive_en,
	input wire logic linear_reg_en,
	input wire logic switch_ctrl_en,
	input wire logic amp_out_en,
	input wire logic reference_en,
	input wire logic [7:0] ss_step
);
	logic [31:0] low_run_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Length of the unbroken feedback-low stretch; saturates so it never wraps back to zero.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_run_q <= 32'h0000_0000;
		end else if (!feedback_sense_low) begin
			low_run_q <= 32'h0000_0000;
		end else if (low_run_q != 32'hFFFF_FFFF) begin
			low_run_q <= low_run_q + 32'h0000_0001;
		end
	end
	sequence s_lockout;
		in_below_fall [*6];
	endsequence
	sequence s_step_moved;
		ss_step != $past(ss_step);
	endsequence
	a_lockout_off: assert property (s_lockout |-> !linear_reg_en && !switch_ctrl_en
		&& !amp_out_en && !open_loop_en && !pwm_en) else $error("outputs on in lockout");
	a_enable_cause: assert property ($rose(device_enable) |-> $past(in_above_rise, 2)
		&& !$past(in_below_fall, 2) && !$past(rail_uv, 2)) else $error("enable without cause");
	a_ref_after_rail: assert property ($rose(reference_en) |->
		$past(internal_supply_rail_ok, 2)) else $error("reference before supply");
	a_pwm_after_ref: assert property ($rose(pwm_en) |-> current_limit_en
		&& $past(ref_ready, 2)) else $error("pwm before reference");
	a_step_equal: assert property (s_step_moved |-> ss_step == $past(ss_step) + 8'h01
		|| ss_step == 8'h80 || ss_step == 8'h00) else $error("soft-start step jump");
	a_fault_time: assert property ($fell(pwm_en) && !in_below_fall && !over_temp
		&& regulator_disable_n && !rail_uv && !rail_ov |-> low_run_q >= FAULT_CYCLES)
		else $error("fault before timer");
	a_latch_hold: assert property ((!amp_out_en && in_above_rise && !in_below_fall) [*8]
		|=> !amp_out_en) else $error("latch released without lockout");
	a_rail_gate: assert property ((rail_uv || rail_ov) [*5] |-> !gate_drive_en)
		else $error("gate driven on bad rail");
	a_thermal_off: assert property (over_temp [*5] |-> !linear_reg_en && !pwm_en
		&& !switch_ctrl_en && !amp_out_en) else $error("outputs on when hot");
	a_boost_disable: assert property ((!regulator_disable_n) [*6] |-> !pwm_en
		&& !gate_drive_en && !open_loop_en) else $error("boost on while disabled");
	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
		wb_ack_o != wb_err_o) else $error("bus answer missing");
endmodule

bind bss_sequencer bss_checker #(.FAULT_CYCLES(FAULT_CYCLES)) u_bss_checker (.*);

/* File: bss_analog_model.sv */
// Behavioural model of the comparators, switch and rails around the sequencer.
`timescale 1ns/1ps
module bss_analog_model (
	input wire logic clk,
	input wire logic [1:0] lvl,
	input wire logic force_uv,
	input wire logic force_ov,
	input wire logic hot,
	input wire logic short_fb,
	input wire logic open_loop_en,
	input wire logic reference_en,
	input wire logic pwm_en,
	output logic in_above_rise,
	output logic in_below_fall,
	output logic rail_uv,
	output logic rail_ov,
	output logic internal_supply_rail_ok,
	output logic ref_ready,
	output logic feedback_sense_low,
	output logic feedback_sense_reg,
	output logic over_temp
);
	logic [7:0] vl_q = 8'h00;
	logic [7:0] ref_q = 8'h00;
	logic [7:0] fb_q = 8'h00;
	// Level 1 sits between the two thresholds, so neither comparator trips there.
	assign in_above_rise = lvl == 2'h2;
	assign in_below_fall = lvl == 2'h0;
	assign rail_uv = in_below_fall || force_uv;
	assign rail_ov = force_ov;
	assign over_temp = hot;
	assign internal_supply_rail_ok = vl_q == 8'h08;
	assign ref_ready = ref_q == 8'h08;
	assign feedback_sense_reg = fb_q == 8'h64;
	assign feedback_sense_low = !feedback_sense_reg;
	always @(posedge clk) begin
		vl_q <= in_below_fall ? 8'h00 : vl_q + 8'((open_loop_en && vl_q < 8'h08) ? 1 : 0);
		ref_q <= !reference_en ? 8'h00 : ref_q + 8'((ref_q < 8'h08) ? 1 : 0);
		fb_q <= (!pwm_en || short_fb) ? 8'h00 : fb_q + 8'((fb_q < 8'h64) ? 1 : 0);
	end
endmodule

/* File: tb.sv */
// Self-checking bench for the boost startup and fault sequencer.
`timescale 1ns/1ps
module tb;
	localparam int STEP_CYC = 4;
	localparam int SS_CYC = 600;
	localparam int FLT_CYC = 50;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic force_uv = 1'b0;
	logic force_ov = 1'b0;
	logic hot = 1'b0;
	logic short_fb = 1'b0;
	logic regulator_disable_n = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd_q;
	logic [7:0] ss_step;
	logic wb_ack_o, wb_err_o, device_enable, open_loop_en, pwm_en, current_limit_en, err_q;
	logic gate_drive_en, linear_reg_en, switch_ctrl_en, amp_out_en, reference_en, irq;
	logic in_above_rise, in_below_fall, rail_uv, rail_ov, internal_supply_rail_ok;
	logic ref_ready, feedback_sense_low, feedback_sense_reg, over_temp;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int n, t0;
	always #2 clk = ~clk;
	bss_sequencer #(.SS_STEP_CYCLES(STEP_CYC), .SS_TIMEOUT_CYCLES(SS_CYC),
		.FAULT_CYCLES(FLT_CYC)) DUT (.*);
	bss_analog_model u_analog (.*);
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", w, exp, seen);
		end
	endtask
	// The master waits for whichever answer comes; only the cycle limit ends the wait.
	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hF, d};
		do begin
			@(posedge clk);
			k++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd_q = wb_dat_o;
		err_q = wb_err_o;
		chk("bus answer", wb_ack_o ^ wb_err_o, 32'h1);
		chk("bus latency", k, 32'h2);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// A write lands at the ack edge, so let the registers settle before callers look.
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string w);
		wb(a, 1'b0, 32'h0);
		chk(w, rd_q & m, e);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return open_loop_en;
			1: return reference_en;
			2: return pwm_en;
			3: return !pwm_en;
			default: return ss_step == 8'h80;
		endcase
	endfunction
	task automatic wait_sig(input int s);
		n = 0;
		while (sig(s) !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk("wait", n < 2000, 32'h1);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		chk("reset outputs", {device_enable, linear_reg_en, amp_out_en, pwm_en, irq}, 32'h0);
		resetn <= 1'b1;
		rd(bss_pkg::ADDR_IRQ_MASK, 32'hFF, 32'(bss_pkg::MASK_RESET), "mask reset");
		rd(bss_pkg::ADDR_CTRL, 32'hFFFF_FFFF, bss_pkg::CTRL_RESET, "ctrl reset");
		wb(8'h14, 1'b0, 32'h0);
		chk("unmapped", err_q, 32'h1);
		lvl <= 2'h2;
		wait_sig(0);
		chk("ref early", reference_en, 32'h0);
		chk("enable", device_enable, 32'h1);
		wait_sig(1);
		chk("rail ok", internal_supply_rail_ok, 32'h1);
		wait_sig(2);
		chk("limit on", {current_limit_en, ref_ready}, 32'h3);
		repeat (10 * STEP_CYC) @(posedge clk);
		chk("ramp", ss_step > 8'h05 && ss_step < 8'h10, 32'h1);
		wait_sig(4);
		chk("ramp end", n < 75, 32'h1);
		rd(bss_pkg::ADDR_STATUS, 32'h43F, 32'h410, "run state");
		chk("irq masked", irq, 32'h0);
		wb(bss_pkg::ADDR_IRQ_MASK, 1'b1, 32'h4);
		chk("irq raised", irq, 32'h1);
		wb(bss_pkg::ADDR_IRQ_STAT, 1'b1, 32'h4);
		chk("irq cleared", irq, 32'h0);
		lvl <= 2'h1;
		repeat (20) @(posedge clk);
		chk("band", {linear_reg_en, pwm_en}, 32'h3);
		lvl <= 2'h2;
		for (int i = 0; i < 2; i++) begin
			{force_ov, force_uv} <= (i == 0) ? 2'h2 : 2'h1;
			repeat (20) @(posedge clk);
			chk("gate blocked", gate_drive_en, 32'h0);
			{force_ov, force_uv} <= 2'h0;
			wait_sig(2);
			repeat (120) @(posedge clk);
			rd(bss_pkg::ADDR_STATUS, 32'h80, 32'h0, "no rail latch");
			chk("gate back", gate_drive_en, 32'h1);
		end
		regulator_disable_n <= 1'b0;
		wb(bss_pkg::ADDR_CTRL, 1'b1, 32'h1);
		repeat (20) @(posedge clk);
		chk("boost only", {pwm_en, gate_drive_en, amp_out_en, switch_ctrl_en}, 32'h3);
		rd(bss_pkg::ADDR_CTRL, 32'hFF, 32'h1, "ctrl");
		wb(bss_pkg::ADDR_CTRL, 1'b1, 32'h0);
		regulator_disable_n <= 1'b1;
		wait_sig(2);
		repeat (120) @(posedge clk);
		short_fb <= 1'b1;
		wait_sig(3);
		chk("fault time", n >= FLT_CYC && n <= FLT_CYC + 10, 32'h1);
		chk("fault off", {linear_reg_en, switch_ctrl_en, amp_out_en}, 32'h0);
		rd(bss_pkg::ADDR_STATUS, 32'h80, 32'h80, "fault latch");
		rd(bss_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1, "fault event");
		short_fb <= 1'b0;
		repeat (100) @(posedge clk);
		chk("latch holds", linear_reg_en, 32'h0);
		lvl <= 2'h0;
		repeat (10) @(posedge clk);
		rd(bss_pkg::ADDR_STATUS, 32'h4FF, 32'h1, "idle");
		chk("lockout", {linear_reg_en, switch_ctrl_en, amp_out_en, open_loop_en}, 32'h0);
		{short_fb, lvl} <= 3'h6;
		wait_sig(2);
		t0 = cycles;
		repeat (SS_CYC - 40) @(posedge clk);
		rd(bss_pkg::ADDR_STATUS, 32'hBF, 32'h8, "still soft");
		wait_sig(3);
		n = cycles - t0;
		chk("timeout", n >= SS_CYC + FLT_CYC && n <= SS_CYC + FLT_CYC + 12, 32'h1);
		{short_fb, lvl} <= 3'h0;
		repeat (10) @(posedge clk);
		lvl <= 2'h2;
		wait_sig(2);
		repeat (120) @(posedge clk);
		hot <= 1'b1;
		repeat (10) @(posedge clk);
		chk("hot", {linear_reg_en, switch_ctrl_en, amp_out_en, pwm_en, device_enable}, 32'h0);
		rd(bss_pkg::ADDR_STATUS, 32'h40, 32'h40, "thermal");
		hot <= 1'b0;
		repeat (50) @(posedge clk);
		chk("hot holds", amp_out_en, 32'h0);
		lvl <= 2'h0;
		repeat (10) @(posedge clk);
		lvl <= 2'h2;
		wait_sig(2);
		close_out();
	end
endmodule
